// ==== logic/queue_pkg.sv ====
`default_nettype none
package queue_pkg;
  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [11:0] STATION_MATCH_OFS = 12'h02C;
  localparam logic [11:0] QUEUE_SETUP_OFS = 12'hE00;
  localparam logic [11:0] QUEUE_PUSH_OFS = 12'hE20;
  localparam logic [11:0] QUEUE_POP_OFS = 12'hE30;
  localparam logic [11:0] QUEUE_LEVEL_OFS = 12'hE04;
  localparam logic [7:0] STATION_MATCH_RST = 8'h00;
  // ********************************************************
  // queue_setup field positions
  // ********************************************************
  localparam int TX_ON_BIT = 0;
  localparam int RX_ON_BIT = 1;
  localparam int SIZE_LO_BIT = 4;
  localparam int TX_DMA_BIT = 12;
  localparam int RX_DMA_BIT = 13;
  localparam int TX_FLUSH_BIT = 16;
  localparam int RX_FLUSH_BIT = 17;
  localparam logic [1:0] SIZE_16X8 = 2'h0;
  localparam int QUEUE_DEPTH = 16;
  localparam int QUEUE_WIDTH = 8;
  localparam int LVL_LO_BIT = 8;
  localparam int RX_LVL_LO_BIT = 16;
  typedef struct packed {
    logic tx_queue_on;
    logic rx_queue_on;
    logic tx_transfer_request_on;
    logic rx_transfer_request_on;
  } setup_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;
endpackage : queue_pkg
`default_nettype wire

// ==== logic/byte_queue.sv ====
`default_nettype none
module byte_queue
  import queue_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW = $clog2(QUEUE_DEPTH)
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic [AW:0] level
);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] level_r;
  // full compare at level width: the pointer width cannot hold DEPTH itself
  wire do_push = push && (level_r != (AW+1)'(DEPTH));
  wire do_pop = pop && (level_r != '0);
  assign level = level_r;
  // read data registered; after a pop the next entry shows at the same edge, a byte written to the head shows one cycle later
  always_ff @(posedge mclk)
  begin
    pop_data <= mem[do_pop ? rptr_r + 1'b1 : rptr_r];
    if (do_push)
      mem[wptr_r] <= push_data;
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      level_r <= '0;
    end
    else if (flush)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      level_r <= '0;
    end
    else
    begin
      wptr_r <= wptr_r + AW'(do_push);
      rptr_r <= rptr_r + AW'(do_pop);
      level_r <= level_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : byte_queue
`default_nettype wire

// ==== logic/serial_queue_regs.sv ====
// Overview of operation
// - eight-bit station match value in bits 7:0, reset zero.
// - compare addresses only when detect and auto-match both set.
// - bit 0 enables transmit queue, resets off.
// - bit 1 enables receive queue, resets off.
// - read-only size field 5:4 reads 0, sixteen 8-bit entries.
// - transmit DMA request while enabled and transmit queue not full.
// - receive DMA bit zero means no receive request.
// - receive DMA request while enabled and receive queue non-empty.
// - flush bits empty their queue, write-only.
`default_nettype none
module serial_queue_regs
  import queue_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic station_detect_on,
  input wire logic auto_station_match_on,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr,
  output logic station_hit,
  input wire logic tx_drain,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  input wire logic rx_fill,
  input wire logic [7:0] rx_fill_data,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  localparam int AW = $clog2(QUEUE_DEPTH);
  // ********************************************************
  // bus decode
  // ********************************************************
  logic [7:0] station_r;
  setup_t setup_r;
  logic [AW:0] tx_lvl;
  logic [AW:0] rx_lvl;
  logic [7:0] tx_head;
  logic [7:0] rx_head;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_match = paddr == STATION_MATCH_OFS;
  wire hit_setup = paddr == QUEUE_SETUP_OFS;
  wire hit_push = paddr == QUEUE_PUSH_OFS;
  wire hit_pop = paddr == QUEUE_POP_OFS;
  wire hit_level = paddr == QUEUE_LEVEL_OFS;
  wire mapped = hit_match || hit_setup || hit_push || hit_pop || hit_level;
  // two-cycle access phase; pready is a flop so it rises one edge late
  wire take = access && !pready;
  wire tx_full = tx_lvl == (AW+1)'(QUEUE_DEPTH);
  wire tx_flush = take && wr && hit_setup && pwdata[TX_FLUSH_BIT];
  wire rx_flush = take && wr && hit_setup && pwdata[RX_FLUSH_BIT];
  // pushes dropped while a queue is off: disabled queue takes no data
  wire tx_push = take && wr && hit_push && setup_r.tx_queue_on;
  wire rx_push = rx_fill && setup_r.rx_queue_on;
  wire rx_pop = take && rd && hit_pop;
  wire tx_pop = tx_drain && tx_lvl != '0;
  function automatic logic [31:0] setup_word(input setup_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TX_ON_BIT] = s.tx_queue_on;
    w[RX_ON_BIT] = s.rx_queue_on;
    w[SIZE_LO_BIT +: 2] = SIZE_16X8;
    w[TX_DMA_BIT] = s.tx_transfer_request_on;
    w[RX_DMA_BIT] = s.rx_transfer_request_on;
    return w;
  endfunction : setup_word
  wire [31:0] rd_mux = hit_match ? {24'h000000, station_r} :
    hit_setup ? setup_word(setup_r) :
    hit_pop ? {24'h000000, rx_head} :
    hit_level ? {11'h000, 5'(rx_lvl), 3'h0, 5'(tx_lvl), 8'h00} : 32'h0000_0000;
  // ********************************************************
  // queues
  // ********************************************************
  byte_queue #(.DEPTH(QUEUE_DEPTH), .AW(AW)) u_txq (
    .mclk(mclk), .reset_n(reset_n), .flush(tx_flush || !setup_r.tx_queue_on),
    .push(tx_push), .push_data(pwdata[7:0]), .pop(tx_pop),
    .pop_data(tx_head), .level(tx_lvl));
  byte_queue #(.DEPTH(QUEUE_DEPTH), .AW(AW)) u_rxq (
    .mclk(mclk), .reset_n(reset_n), .flush(rx_flush || !setup_r.rx_queue_on),
    .push(rx_push), .push_data(rx_fill_data), .pop(rx_pop),
    .pop_data(rx_head), .level(rx_lvl));
  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      station_r <= STATION_MATCH_RST;
      setup_r <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      station_hit <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      tx_data <= 8'h00;
      tx_data_valid <= 1'b0;
    end
    else
    begin
      pready <= take;
      pslverr <= take && !mapped;
      prdata <= (take && rd) ? rd_mux : prdata;
      if (take && wr && hit_match)
        station_r <= pwdata[7:0];
      if (take && wr && hit_setup)
      begin
        setup_r.tx_queue_on <= pwdata[TX_ON_BIT];
        setup_r.rx_queue_on <= pwdata[RX_ON_BIT];
        setup_r.tx_transfer_request_on <= pwdata[TX_DMA_BIT];
        setup_r.rx_transfer_request_on <= pwdata[RX_DMA_BIT];
      end
      station_hit <= rx_addr_valid && station_detect_on && auto_station_match_on
        && rx_addr == station_r;
      tx_dma_req <= setup_r.tx_transfer_request_on && setup_r.tx_queue_on
        && !tx_full;
      rx_dma_req <= setup_r.rx_transfer_request_on && rx_lvl != '0;
      tx_data_valid <= tx_pop;
      tx_data <= tx_pop ? tx_head : tx_data;
    end
  end
  // ********************************************************
  // checks
  // ********************************************************
  property p_match_reset;
    @(posedge mclk) $rose(reset_n) |-> station_r == STATION_MATCH_RST;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("match reset");
  property p_hit_gate;
    @(posedge mclk) disable iff (!reset_n)
      station_hit |-> $past(station_detect_on) && $past(auto_station_match_on);
  endproperty
  a_hit_gate: assert property (p_hit_gate) else $error("match ungated");
  property p_size_ro;
    @(posedge mclk) disable iff (!reset_n)
      (take && rd && hit_setup) |=> prdata[SIZE_LO_BIT +: 2] == SIZE_16X8;
  endproperty
  a_size_ro: assert property (p_size_ro) else $error("size not zero");
  property p_tx_req;
    @(posedge mclk) disable iff (!reset_n)
      (setup_r.tx_transfer_request_on && setup_r.tx_queue_on && !tx_full)
      |=> tx_dma_req;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("tx request missing");
  property p_rx_off;
    @(posedge mclk) disable iff (!reset_n)
      !setup_r.rx_transfer_request_on |=> !rx_dma_req;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx request while off");
  property p_rx_req;
    @(posedge mclk) disable iff (!reset_n)
      (setup_r.rx_transfer_request_on && rx_lvl != '0) |=> rx_dma_req;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request missing");
  property p_flush;
    @(posedge mclk) disable iff (!reset_n) tx_flush |=> tx_lvl == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("flush left data");
  property p_rsvd;
    @(posedge mclk) disable iff (!reset_n)
      (take && rd && hit_match) |=> prdata[31:8] == 24'h000000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  // ********************************************************
  // handshake and queue checks
  // ********************************************************
  // exactly one wait state; masters may lean on it, so keep it fixed
  sequence s_taken;
    take;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_answer;
    @(posedge mclk) disable iff (!reset_n) s_taken |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not one cycle");
  property p_err_ready;
    @(posedge mclk) disable iff (!reset_n) pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_tx_held;
    @(posedge mclk) disable iff (!reset_n) !setup_r.tx_queue_on |=> tx_lvl == '0;
  endproperty
  a_tx_held: assert property (p_tx_held) else $error("tx queue filled while off");
  property p_rx_held;
    @(posedge mclk) disable iff (!reset_n) !setup_r.rx_queue_on |=> rx_lvl == '0;
  endproperty
  a_rx_held: assert property (p_rx_held) else $error("rx queue filled while off");
  property p_tx_off;
    @(posedge mclk) disable iff (!reset_n)
      !setup_r.tx_transfer_request_on |=> !tx_dma_req;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx request while off");
  property p_rx_flush;
    @(posedge mclk) disable iff (!reset_n) rx_flush |=> rx_lvl == '0;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");
  // a drain against a non-empty queue must hand a byte over
  sequence s_drain;
    tx_drain && tx_lvl != '0;
  endsequence
  property p_drain;
    @(posedge mclk) disable iff (!reset_n) s_drain |=> tx_data_valid;
  endproperty
  a_drain: assert property (p_drain) else $error("drain gave no byte");
  property p_hit_value;
    @(posedge mclk) disable iff (!reset_n)
      station_hit |-> $past(rx_addr_valid) && $past(rx_addr) == $past(station_r);
  endproperty
  a_hit_value: assert property (p_hit_value) else $error("hit on wrong address");
endmodule : serial_queue_regs
`default_nettype wire

// ==== test/line_side_model.sv ====
`default_nettype none
module line_side_model
(
  input wire logic mclk,
  output logic rx_fill,
  output logic [7:0] rx_fill_data,
  output logic tx_drain
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // serial engine stand-in, one pulse a byte
  // ****************************************
  initial
  begin
    rx_fill = 1'b0;
    rx_fill_data = 8'h00;
    tx_drain = 1'b0;
  end
  task fill(input logic [7:0] d);
    @(posedge mclk);
    rx_fill <= 1'b1;
    rx_fill_data <= d;
    @(posedge mclk);
    rx_fill <= 1'b0;
    // idle data inverted so a stale byte is never mistaken for fresh
    rx_fill_data <= ~d;
  endtask : fill
  task drain();
    @(posedge mclk);
    tx_drain <= 1'b1;
    @(posedge mclk);
    tx_drain <= 1'b0;
  endtask : drain
endmodule : line_side_model
`default_nettype wire

// ==== test/usart_match_and_fifo_setup_test.sv ====
`default_nettype none
module usart_match_and_fifo_setup_test
  import queue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, det = 0, auto = 0, av = 0, hit, txv, txr, rxr;
  logic [7:0] ad = 8'h00, txd, fd;
  logic fv, dr;
  int bad_count = 0, compares = 0;
  logic [11:0] ra [3] = '{12'h02C, 12'hE00, 12'h100};
  logic [31:0] rw [3] = '{32'hFFFFFFFF, 32'h00003033, 32'h12345678};
  logic [31:0] rx [3] = '{32'h000000FF, 32'h00003003, 32'h00000000};
  always #5 mclk = ~mclk;
  serial_queue_regs i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .station_detect_on(det), .auto_station_match_on(auto),
    .rx_addr_valid(av), .rx_addr(ad), .station_hit(hit), .tx_drain(dr), .tx_data(txd),
    .tx_data_valid(txv), .rx_fill(fv), .rx_fill_data(fd), .tx_dma_req(txr),
    .rx_dma_req(rxr));
  line_side_model i_line (.mclk(mclk), .rx_fill(fv), .rx_fill_data(fd), .tx_drain(dr));
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait3();
    repeat (3) @(posedge mclk);
    #1;
  endtask : wait3
  task end_sim();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("tx_dma_req reset", 0, txr);
    chk("rx_dma_req reset", 0, rxr);
    apb(0, STATION_MATCH_OFS, 0);
    chk("match reset", 0, rd);
    apb(0, QUEUE_SETUP_OFS, 0);
    chk("setup reset", 0, rd);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, ra[i], rw[i]);
      chk("write err", i == 2, err);
      apb(0, ra[i], 0);
      chk("readback", rx[i], rd);
    end
    wait3();
    chk("tx_dma_req empty", 1, txr);
    chk("rx_dma_req empty", 0, rxr);
    apb(1, QUEUE_SETUP_OFS, 32'h00001003);
    i_line.fill(8'hA5);
    wait3();
    chk("rx_dma_req off", 0, rxr);
    apb(1, QUEUE_SETUP_OFS, 32'h00003003);
    wait3();
    chk("rx_dma_req one", 1, rxr);
    apb(0, QUEUE_POP_OFS, 0);
    chk("pop", 32'h000000A5, rd);
    wait3();
    chk("rx_dma_req drained", 0, rxr);
    for (int i = 0; i < 16; i++) apb(1, QUEUE_PUSH_OFS, i + 32'h10);
    wait3();
    chk("tx_dma_req full", 0, txr);
    i_line.drain();
    #1;
    chk("tx_data", 32'h00000110, {txv, txd});
    wait3();
    chk("tx_dma_req room", 1, txr);
    apb(1, QUEUE_SETUP_OFS, 32'h00013003);
    apb(0, QUEUE_LEVEL_OFS, 0);
    chk("level flushed", 0, rd);
    apb(0, QUEUE_SETUP_OFS, 0);
    chk("flush bit", 32'h00003003, rd);
    apb(1, QUEUE_SETUP_OFS, 32'h00003002);
    wait3();
    chk("tx_dma_req tx off", 0, txr);
    apb(1, STATION_MATCH_OFS, 32'h0000005A);
    // ****************************************
    // match enables, then a wrong address
    // ****************************************
    for (int k = 0; k < 5; k++)
    begin
      @(posedge mclk);
      det <= k[0] | (k > 2);
      auto <= k[1] | (k > 2);
      ad <= (k == 4) ? 8'h5B : 8'h5A;
      av <= 1'b1;
      @(posedge mclk);
      av <= 1'b0;
      #1;
      chk("station_hit", k == 3, hit);
    end
    // ****************************************
    // receive level, receive flush, queues off
    // ****************************************
    i_line.fill(8'h3C);
    i_line.fill(8'hC3);
    apb(0, QUEUE_LEVEL_OFS, 0);
    chk("rx level", 32'h00020000, rd);
    chk("rx_dma_req two", 1, rxr);
    apb(1, QUEUE_SETUP_OFS, 32'h00023002);
    apb(0, QUEUE_LEVEL_OFS, 0);
    chk("rx level flushed", 0, rd);
    apb(1, QUEUE_SETUP_OFS, 32'h00000000);
    i_line.fill(8'h77);
    apb(1, QUEUE_PUSH_OFS, 32'h00000099);
    apb(0, QUEUE_LEVEL_OFS, 0);
    chk("queues off", 0, rd);
    // ****************************************
    // reset in mid-run
    // ****************************************
    apb(1, QUEUE_SETUP_OFS, 32'h00003003);
    wait3();
    chk("tx_dma_req before reset", 1, txr);
    @(posedge mclk);
    reset_n <= 1'b0;
    wait3();
    chk("tx_dma_req in reset", 0, txr);
    chk("pready in reset", 0, pready);
    @(posedge mclk);
    reset_n <= 1'b1;
    apb(0, STATION_MATCH_OFS, 0);
    chk("match after reset", 0, rd);
    apb(0, QUEUE_SETUP_OFS, 0);
    chk("setup after reset", 0, rd);
    end_sim();
  end
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule : usart_match_and_fifo_setup_test
`default_nettype wire
